/* logic/sdm_pkg.sv */
// Purpose: Shared constants for the synchronous DRAM core
// Assumes: Commands decoded from {cs_n, ras_n, cas_n, we_n}
// Notes: Mode word field positions and codes live here

package sdm_pkg;

    // Array geometry
    localparam int NUM_BANKS = 2;
    localparam int ROW_W = 11;
    localparam int COL_W = 8;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 11;
    localparam int MODE_W = 12;
    localparam int FIFO_DEPTH = 4;

    // Command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_TERM = 4'h6;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_LOAD = 4'h0;

    // Mode word fields
    localparam int MR_BL_LSB = 0;
    localparam int MR_BL_MSB = 2;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_CL_MSB = 6;
    localparam int MR_OPM_LSB = 7;
    localparam int MR_OPM_MSB = 8;
    localparam int MR_WB_BIT = 9;
    localparam int MR_SEL_BIT = 11;

    // Field codes
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] CL_1 = 3'h1;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [1:0] OPM_STD = 2'h0;

    // Reset values
    localparam logic [11:0] MODE_RESET = 12'h020;
    localparam logic [11:0] EXT_RESET = 12'h800;

    typedef enum logic [2:0] {
        SDM_ST_IDLE = 3'h1,
        SDM_ST_READ = 3'h2,
        SDM_ST_WRITE = 3'h4
    } sdm_state_t;

endpackage

/* logic/sdm_fifo.sv */
// Purpose: Small flop-based FIFO with valid/ready on both sides
// Assumes: clk_en low freezes all state
// Notes: in_ready low exactly when full

`timescale 1ns/100ps
`default_nettype none

module sdm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire push = clk_en && in_valid && in_ready;
    wire pop = clk_en && out_valid && out_ready;
    wire [AW-1:0] next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
    wire [AW-1:0] next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);

    assign in_ready = count != (AW + 1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = store[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= next_wr_ptr;
            end
            if (pop) begin
                rd_ptr <= next_rd_ptr;
            end
            if (push && !pop) begin
                count <= count + (AW + 1)'(1);
            end else if (pop && !push) begin
                count <= count - (AW + 1)'(1);
            end
        end
    end

endmodule // sdm_fifo

`default_nettype wire

/* logic/sdm_core.sv */
// Purpose: Command decode, mode word and burst sequencing of a two-bank DRAM
// Assumes: Controller keeps power-up wait, precharge and refresh order
// Notes: Write data passes a small FIFO before reaching the array
//
// Functional notes
// - Two banks, 2048 rows by 256 columns of 32-bit words each.
// - All command, address and control inputs sampled on rising clock only.
// - Activate latches bank and row; read or write to that bank follows.
// - Read or write takes A0..A7 as the burst start column.
// - Mode word written only by load command; holds until rewritten.
// - Mode word: length, order, latency, operating_mode_field, write-burst; top bits zero (core stores A10 in bit 10, forces only bit 11 to zero).
// - Length codes give 1, 2, 4, 8; code 111 full page sequential.
// - Order bit: zero sequential, one interleaved.
// - Latency codes 001, 010, 011 give one, two, three clocks.
// - Operating_mode_field zero is standard; other values reserved.
// - Write-burst bit set makes writes single-location; reads still burst.
// - Full page spans 256 columns, wraps, cut by burst terminate.
// - Burst stays inside aligned block of its length, wrapping at boundary.
// - Length one accesses only the given column, ignoring order bit.
// - Sequential: low bits are start plus beat index modulo length.
// - Interleaved: low bits are start XOR beat index.
// - Latency q: drive from edge r+q-1, valid data by edge r+q.
// - Load command takes the new word from address and bank select.
// - Load with bank select high writes the extended word instead.

`timescale 1ns/100ps
`default_nettype none

module sdm_core #(
    parameter int ROW_W = sdm_pkg::ROW_W,
    parameter int COL_W = sdm_pkg::COL_W,
    parameter int DATA_W = sdm_pkg::DATA_W,
    parameter int FIFO_DEPTH = sdm_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_select,
    input wire logic [sdm_pkg::ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic write_stall,
    output logic burst_busy,
    output logic [sdm_pkg::MODE_W-1:0] operating_mode_word,
    output logic [sdm_pkg::MODE_W-1:0] extended_setting_word
);
    localparam int IDX_W = 1 + ROW_W + COL_W;
    localparam int FIFO_W = IDX_W + DATA_W;

    // Column of a beat inside its aligned block
    function automatic logic [COL_W-1:0] col_of(
        input logic [COL_W-1:0] start,
        input logic [COL_W-1:0] idx,
        input logic [COL_W-1:0] mask,
        input logic seq
    );
        logic [COL_W-1:0] low;
        low = seq ? COL_W'(start + idx) : (start ^ idx);
        return (start & ~mask) | (low & mask);
    endfunction

    logic [DATA_W-1:0] mem [0:(1 << IDX_W)-1];
    logic [ROW_W-1:0] open_row [0:sdm_pkg::NUM_BANKS-1];
    sdm_pkg::sdm_state_t state;
    sdm_pkg::sdm_state_t next_state;
    logic [COL_W-1:0] beat;
    logic [COL_W-1:0] next_beat;
    logic [COL_W-1:0] bst_start;
    logic [COL_W-1:0] bst_mask;
    logic bst_seq;
    logic bst_full;
    logic bst_bank;
    logic [ROW_W-1:0] bst_row;
    logic [1:0] pipe_v;
    logic [DATA_W-1:0] pipe_d0;
    logic [DATA_W-1:0] pipe_d1;
    logic fifo_in_ready;
    logic drain_valid;
    logic [FIFO_W-1:0] drain_word;

    // Command decode, inputs taken at the rising edge only
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire cmd_nop = cs_n || cmd == sdm_pkg::CMD_NOP;
    wire is_act = clk_en && cmd == sdm_pkg::CMD_ACT;
    wire is_rd = clk_en && cmd == sdm_pkg::CMD_READ;
    wire is_wr = clk_en && cmd == sdm_pkg::CMD_WRITE;
    wire is_term = clk_en && cmd == sdm_pkg::CMD_TERM;
    wire is_pre = clk_en && cmd == sdm_pkg::CMD_PRE;
    wire is_load = clk_en && cmd == sdm_pkg::CMD_LOAD;

    // Mode word fields
    wire [2:0] bl_code = operating_mode_word[sdm_pkg::MR_BL_MSB:sdm_pkg::MR_BL_LSB];
    wire bt_bit = operating_mode_word[sdm_pkg::MR_BT_BIT];
    wire [2:0] cl_code = operating_mode_word[sdm_pkg::MR_CL_MSB:sdm_pkg::MR_CL_LSB];
    wire [1:0] opm = operating_mode_word[sdm_pkg::MR_OPM_MSB:sdm_pkg::MR_OPM_LSB];
    wire wb_bit = operating_mode_word[sdm_pkg::MR_WB_BIT];
    wire std_mode = opm == sdm_pkg::OPM_STD;
    wire full_page = bl_code == sdm_pkg::BL_FULL && !bt_bit;
    wire [COL_W-1:0] blk_mask = full_page ? '1 :
        (bl_code == sdm_pkg::BL_2) ? COL_W'(1) :
        (bl_code == sdm_pkg::BL_4) ? COL_W'(3) :
        (bl_code == sdm_pkg::BL_8) ? COL_W'(7) : '0;

    // Access starts and burst beats
    wire rd_cmd = is_rd && std_mode;
    wire wr_cmd = is_wr && std_mode;
    wire new_acc = rd_cmd || wr_cmd;
    wire [COL_W-1:0] new_mask = (wr_cmd && wb_bit) ? '0 : blk_mask;
    wire stop = is_term || is_pre || new_acc;
    wire burst_beat = clk_en && state != sdm_pkg::SDM_ST_IDLE && !stop;
    wire rd_beat = rd_cmd || (burst_beat && state == sdm_pkg::SDM_ST_READ);
    wire wr_beat = wr_cmd || (burst_beat && state == sdm_pkg::SDM_ST_WRITE);
    wire [COL_W-1:0] burst_col = col_of(bst_start, beat, bst_mask, bst_seq);

    // Access address: command cycle uses pins, later beats the burst state
    wire acc_bank = new_acc ? bank_select : bst_bank;
    wire [ROW_W-1:0] acc_row = new_acc ? open_row[bank_select] : bst_row;
    wire [COL_W-1:0] acc_col = new_acc ? addr[COL_W-1:0] : burst_col;
    wire [IDX_W-1:0] acc_idx = {acc_bank, acc_row, acc_col};
    wire [DATA_W-1:0] rd_word = mem[acc_idx];

    // Read latency selection, reserved codes behave as three
    wire lat1 = cl_code == sdm_pkg::CL_1;
    wire lat2 = cl_code == sdm_pkg::CL_2;
    wire next_oe = lat1 ? rd_beat : (lat2 ? pipe_v[0] : pipe_v[1]);
    wire [DATA_W-1:0] next_dq = lat1 ? rd_word : (lat2 ? pipe_d0 : pipe_d1);

    // Write path: array port goes to reads first, drain stalls meanwhile
    wire drain_ready = clk_en && !rd_beat;
    wire [IDX_W-1:0] drain_idx = drain_word[FIFO_W-1:DATA_W];

    assign write_stall = !fifo_in_ready;
    assign burst_busy = state != sdm_pkg::SDM_ST_IDLE;

    sdm_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_valid(wr_beat),
        .in_ready(fifo_in_ready),
        .in_data({acc_idx, dq_in}),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_word)
    );

    always_comb begin
        next_state = state;
        next_beat = beat;
        if (new_acc) begin
            next_beat = COL_W'(1);
            if (new_mask == '0) begin
                next_state = sdm_pkg::SDM_ST_IDLE;
            end else begin
                next_state = rd_cmd ? sdm_pkg::SDM_ST_READ : sdm_pkg::SDM_ST_WRITE;
            end
        end else if (stop) begin
            next_state = sdm_pkg::SDM_ST_IDLE;
        end else if (burst_beat) begin
            next_beat = beat + COL_W'(1);
            case (state)
                sdm_pkg::SDM_ST_READ, sdm_pkg::SDM_ST_WRITE: begin
                    if (!bst_full && beat == bst_mask) begin
                        next_state = sdm_pkg::SDM_ST_IDLE;
                    end
                end
                default: begin
                    next_state = sdm_pkg::SDM_ST_IDLE;
                end
            endcase
        end
    end

    // Array storage, no reset
    always_ff @(posedge clk_sys) begin
        if (drain_valid && drain_ready) begin
            mem[drain_idx] <= drain_word[DATA_W-1:0];
        end
    end

    // Burst state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= sdm_pkg::SDM_ST_IDLE;
            beat <= '0;
        end else if (clk_en) begin
            state <= next_state;
            beat <= next_beat;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bst_start <= '0;
            bst_mask <= '0;
            bst_seq <= 1'b1;
            bst_full <= 1'b0;
            bst_bank <= 1'b0;
            bst_row <= '0;
        end else if (new_acc) begin
            bst_start <= addr[COL_W-1:0];
            bst_mask <= new_mask;
            bst_seq <= !bt_bit;
            bst_full <= full_page && !(wr_cmd && wb_bit);
            bst_bank <= bank_select;
            bst_row <= open_row[bank_select];
        end
    end

    // Open row per bank
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int b = 0; b < sdm_pkg::NUM_BANKS; b++) begin
                open_row[b] <= '0;
            end
        end else if (is_act) begin
            open_row[bank_select] <= addr[ROW_W-1:0];
        end
    end

    // Mode and extended words
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            operating_mode_word <= sdm_pkg::MODE_RESET;
            extended_setting_word <= sdm_pkg::EXT_RESET;
        end else if (is_load && !bank_select) begin
            operating_mode_word <= {1'b0, addr};
        end else if (is_load) begin
            extended_setting_word <= {1'b1, addr};
        end
    end

    // Read data pipeline and pins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pipe_v <= '0;
            pipe_d0 <= '0;
            pipe_d1 <= '0;
            dq_oe_n <= 1'b1;
            dq_out <= '0;
        end else if (clk_en) begin
            pipe_v <= {pipe_v[0], rd_beat};
            pipe_d0 <= rd_word;
            pipe_d1 <= pipe_d0;
            dq_oe_n <= !next_oe;
            dq_out <= next_oe ? next_dq : dq_out;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    AST_MODE_LOAD: assert property (is_load && !bank_select |=>
        operating_mode_word[10:0] == $past(addr) && !operating_mode_word[11])
        else $error("mode word not taken from address pins");
    AST_EXT_LOAD: assert property (is_load && bank_select |=>
        extended_setting_word[10:0] == $past(addr) && $stable(operating_mode_word))
        else $error("extended load disturbed mode word");
    AST_MODE_HOLD: assert property (!(is_load && !bank_select) |=>
        $stable(operating_mode_word))
        else $error("mode word changed without load");
    AST_LAT_ONE: assert property (rd_cmd && lat1 |=>
        !dq_oe_n && dq_out == $past(rd_word))
        else $error("latency one data late");
    AST_LAT_TWO: assert property (rd_cmd && lat2 ##1 clk_en |=>
        !dq_oe_n)
        else $error("latency two data late");
    AST_LEN_FOUR: assert property (rd_cmd && bl_code == sdm_pkg::BL_4 && std_mode
        ##1 (clk_en && cmd_nop) [*3] |=> state == sdm_pkg::SDM_ST_IDLE)
        else $error("length four burst wrong length");
    AST_SEQ_STEP: assert property (burst_beat && bst_seq ##1 burst_beat |->
        (COL_W'(acc_col - $past(acc_col)) & bst_mask) == (COL_W'(1) & bst_mask))
        else $error("sequential step not plus one");
    AST_ILV_ORDER: assert property (burst_beat && !bst_seq |->
        ((acc_col ^ bst_start) & bst_mask) == (beat & bst_mask))
        else $error("interleaved order wrong");
    AST_BLOCK: assert property (burst_beat |->
        (acc_col & ~bst_mask) == (bst_start & ~bst_mask))
        else $error("burst left its block");
    AST_LEN_ONE: assert property (new_acc && bl_code == sdm_pkg::BL_1 |=>
        state == sdm_pkg::SDM_ST_IDLE)
        else $error("length one burst continued");
    AST_WB_SINGLE: assert property (wr_cmd && wb_bit |=>
        state == sdm_pkg::SDM_ST_IDLE)
        else $error("single write continued");
    AST_TERM: assert property (is_term |=> state == sdm_pkg::SDM_ST_IDLE)
        else $error("terminate ignored");
    AST_FULL_WRAP: assert property (burst_beat && bst_full |=>
        state == $past(state))
        else $error("full page burst ended alone");
    AST_FREEZE: assert property (!clk_en |=> $stable(state) && $stable(dq_oe_n))
        else $error("state moved while clock disabled");

    COV_READ_BURST: cover property (rd_cmd ##1 burst_beat ##1 burst_beat);
    COV_WRITE_BURST: cover property (wr_cmd ##1 burst_beat);
    COV_FULL_PAGE: cover property (burst_beat && bst_full && beat == '1);
    COV_STALL: cover property (write_stall);

endmodule // sdm_core

`default_nettype wire

/* dv/sdm_ctrl_model.sv */
// Purpose: Memory controller model driving the DRAM command pins
// Assumes: One command per rising edge, changed just after the edge
// Notes: Idle address and data toggle so stale values never look valid

`timescale 1ns/100ps
`default_nettype none

module sdm_ctrl_model #(
    parameter int WAIT_CYC = 4000,
    parameter int LOAD_GAP = 2
) (
    input wire logic clk_sys,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic bank_select,
    output logic [10:0] addr,
    output logic [31:0] dq_in
);
    // Inhibit from time zero
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        bank_select = 1'b0;
        addr = 11'h000;
        dq_in = 32'h0000_0000;
    end

    task automatic cmd(input logic [3:0] c, input logic b, input logic [10:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        {cs_n, ras_n, cas_n, we_n} <= c;
        bank_select <= b;
        addr <= a;
        dq_in <= d;
    endtask

    task automatic idle(input int n);
        repeat (n) cmd(sdm_pkg::CMD_NOP, ~bank_select, ~addr, ~dq_in);
    endtask

    // Power-up wait, precharge all, two refreshes, both loads, then activates
    task automatic init_seq(input logic [10:0] mw, input logic [10:0] ew,
                            input logic [10:0] r0, input logic [10:0] r1);
        idle(WAIT_CYC);
        cmd(sdm_pkg::CMD_PRE, 1'b0, 11'h400, ~dq_in);
        idle(2);
        repeat (2) begin
            cmd(sdm_pkg::CMD_REF, 1'b0, ~addr, ~dq_in);
            idle(3);
        end
        cmd(sdm_pkg::CMD_LOAD, 1'b0, mw, ~dq_in);
        idle(LOAD_GAP);
        cmd(sdm_pkg::CMD_LOAD, 1'b1, ew, ~dq_in);
        idle(LOAD_GAP);
        cmd(sdm_pkg::CMD_ACT, 1'b0, r0, ~dq_in);
        idle(2);
        cmd(sdm_pkg::CMD_ACT, 1'b1, r1, ~dq_in);
        idle(2);
    endtask
endmodule // sdm_ctrl_model

`default_nettype wire

/* dv/tb_sdram_init_mode_burst.sv */
// Purpose: Self-checking bench for mode word and burst ordering
// Assumes: Rows reopened after each mode load; clock enable dropped once
// Notes: Memory model keyed by bank and column

`timescale 1ns/100ps
`default_nettype none

module tb_sdram_init_mode_burst;
    logic clk_sys;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    wire cs_n, ras_n, cas_n, we_n, bank_select;
    wire [10:0] addr;
    wire [31:0] dq_in;
    logic [31:0] dq_out;
    logic dq_oe_n, write_stall, burst_busy;
    logic [11:0] operating_mode_word, extended_setting_word;
    logic [11:0] mode;
    logic [10:0] rowv [2];
    logic [31:0] mem [int];
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    sdm_ctrl_model u_sdm_ctrl_model (.clk_sys(clk_sys), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select), .addr(addr), .dq_in(dq_in));

    sdm_core u_sdm_core (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select), .addr(addr),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .write_stall(write_stall),
        .burst_busy(burst_busy), .operating_mode_word(operating_mode_word),
        .extended_setting_word(extended_setting_word));

    task automatic final_report();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Column of beat i inside the aligned block
    function automatic int col_of(int s, int i, int len, bit il);
        int m;
        m = len - 1;
        return (s & ~m & 255) | ((il ? (s ^ i) : (s + i)) & m);
    endfunction

    function automatic int blen(logic [11:0] w, bit wr);
        if (wr && w[9])
            return 1;
        case (w[2:0])
            3'h1: return 2;
            3'h2: return 4;
            3'h3: return 8;
            3'h7: return w[3] ? 1 : 256;
            default: return 1;
        endcase
    endfunction

    task automatic nop();
        u_sdm_ctrl_model.cmd(sdm_pkg::CMD_NOP, 1'b0, 11'($urandom), $urandom);
    endtask

    task automatic setm(input logic [11:0] w);
        u_sdm_ctrl_model.cmd(sdm_pkg::CMD_PRE, 1'b0, 11'h400, $urandom);
        nop();
        u_sdm_ctrl_model.cmd(sdm_pkg::CMD_LOAD, 1'b0, w[10:0], $urandom);
        nop();
        #1 chk(operating_mode_word, w);
        mode = w;
        nop();
        u_sdm_ctrl_model.cmd(sdm_pkg::CMD_ACT, 1'b0, rowv[0], $urandom);
        u_sdm_ctrl_model.cmd(sdm_pkg::CMD_ACT, 1'b1, rowv[1], $urandom);
        nop();
    endtask

    task automatic wr(input bit b, input int s);
        int len;
        logic [31:0] d;
        len = blen(mode, 1'b1);
        for (int i = 0; i < len; i++) begin
            d = $urandom;
            u_sdm_ctrl_model.cmd(i == 0 ? sdm_pkg::CMD_WRITE : sdm_pkg::CMD_NOP, b, 11'(s), d);
            #1 chk(write_stall, 1'b0);
            mem[{b, 8'(col_of(s, i, len, mode[3]))}] = d;
        end
        if (len == 256)
            u_sdm_ctrl_model.cmd(sdm_pkg::CMD_TERM, b, 11'(s), $urandom);
        repeat (6) nop();
    endtask

    task automatic rd(input bit b, input int s, input int nb);
        int q;
        q = int'(mode[6:4]);
        u_sdm_ctrl_model.cmd(sdm_pkg::CMD_READ, b, 11'(s), $urandom);
        for (int k = 0; k <= q - 1 + nb; k++) begin
            if (k == nb - 1 && nb > 8)
                u_sdm_ctrl_model.cmd(sdm_pkg::CMD_TERM, b, 11'(s), $urandom);
            else
                nop();
            #1;
            if (k < q - 1)
                chk(dq_oe_n, 1'b1);
            else if (k < q - 1 + nb) begin
                chk(dq_oe_n, 1'b0);
                chk(dq_out, mem[{b, 8'(col_of(s, k - q + 1, blen(mode, 1'b0), mode[3]))}]);
            end
        end
        chk(dq_oe_n, 1'b1);
        chk(burst_busy, 1'b0);
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        void'($urandom(42));
        rowv[0] = 11'($urandom);
        rowv[1] = 11'h7FF;
        repeat (3) @(posedge clk_sys);
        #1 chk(operating_mode_word, 12'h020);
        chk(extended_setting_word, 12'h800);
        chk(dq_oe_n, 1'b1);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        u_sdm_ctrl_model.init_seq(11'h023, 11'h060, rowv[0], rowv[1]);
        #1 chk(extended_setting_word, 12'h860);
        chk(operating_mode_word, 12'h023);
        mode = 12'h023;
        for (int b = 0; b < 2; b++) begin
            wr(1'(b), 0);
            wr(1'(b), 8);
        end
        for (int bl = 0; bl < 4; bl++) begin
            for (int bt = 0; bt < 2; bt++) begin
                for (int cl = 1; cl < 4; cl++) begin
                    setm({5'h00, 3'(cl), 1'(bt), 3'(bl)});
                    wr(1'($urandom), $urandom_range(15));
                    rd(1'($urandom), $urandom_range(15), blen(mode, 1'b0));
                end
            end
        end
        setm(12'h0A2);
        u_sdm_ctrl_model.cmd(sdm_pkg::CMD_WRITE, 1'b0, 11'h001, $urandom);
        u_sdm_ctrl_model.cmd(sdm_pkg::CMD_READ, 1'b0, 11'h001, $urandom);
        repeat (4) begin
            nop();
            #1 chk(dq_oe_n, 1'b1);
        end
        setm(12'h022);
        rd(1'b0, 0, 4);
        setm(12'h222);
        wr(1'b0, 5);
        rd(1'b0, 4, 4);
        setm(12'h017);
        wr(1'b0, 0);
        rd(1'b0, 250, 12);
        u_sdm_ctrl_model.cmd(sdm_pkg::CMD_READ, 1'b0, 11'h000, $urandom);
        clk_en <= 1'b0;
        nop();
        clk_en <= 1'b1;
        #1 chk(dq_oe_n, 1'b1);
        chk(burst_busy, 1'b0);
        repeat (3) nop();
        #1 chk(dq_oe_n, 1'b1);
        final_report();
    end
endmodule // tb_sdram_init_mode_burst

`default_nettype wire
